// ===== core/tseg_timer_status_event.sv
// Timer status flags, event generation, counter, prescaler and capture channels
`timescale 1ns/1ps
`default_nettype none
`include "tseg_consts.svh"
module tseg_timer_status_event
    import tseg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire tseg_bus_t bus,
    output logic [15:0] rdData,
    input wire logic [3:0] chCapture,
    input wire logic trigIn,
    output logic irq,
    output logic [5:0] dmaReq
);
    logic [15:0] ctrl_reg;
    logic [15:0] enable_reg;
    logic [15:0] mode_reg;
    logic [15:0] reload_reg;
    logic [15:0] psc_reg;
    logic [15:0] pscCnt_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cc_reg [4];
    logic [15:0] evgen_reg;
    tseg_state_t state_reg;
    tseg_flags_t flags_reg;
    tseg_flags_t flags_next;
    logic [9:0] irqStat_reg;
    logic [9:0] irqMask_reg;
    logic [15:0] rdData_reg;
    logic [5:0] dma_reg;

    logic wrStat;
    logic rdCc;
    logic [1:0] rdCh;
    logic forceUpd;
    logic forceTrig;
    logic [3:0] forceCh;
    logic [3:0] chInput;
    logic [3:0] capEvt;
    logic [3:0] ccEvt;
    logic overflow;
    logic updEvt;
    logic trigEvt;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
        return bus.wr && a == off;
    endfunction

    // Places the flags at their status register bit positions
    function automatic logic [15:0] statusWord(input tseg_flags_t f);
        return {3'h0, f.ovc, 2'h0, f.trig, 1'b0, f.cc, f.upd};
    endfunction

    function automatic logic isInput(input logic [1:0] sel);
        return sel != 2'h0;
    endfunction

    assign wrStat = hit(bus.addr, `TSEG_OFF_STATUS);
    assign rdCc = bus.rd && bus.addr[5:2] == 4'hd;
    assign rdCh = 2'(bus.addr - `TSEG_OFF_CC1);
    assign forceUpd = state_reg == TSEG_EXEC && evgen_reg[`TSEG_BIT_UPDATE];
    assign forceTrig = state_reg == TSEG_EXEC && evgen_reg[`TSEG_BIT_TRIG];
    assign forceCh = state_reg == TSEG_EXEC ? evgen_reg[4:1] : 4'h0;
    assign overflow = pscCnt_reg == psc_reg && (ctrl_reg[`TSEG_BIT_DOWN] ?
        cnt_reg == 16'h0000 : cnt_reg == reload_reg);
    assign updEvt = forceUpd || overflow;
    assign trigEvt = forceTrig || trigIn;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            chInput[i] = isInput(mode_reg[4*i +: 2]);
            capEvt[i] = chInput[i] && (chCapture[i] || forceCh[i]);
            ccEvt[i] = capEvt[i] || (!chInput[i] && forceCh[i]);
        end
    end

    // Event bits latch on write and are cleared after one execution cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evgen_reg <= `TSEG_RESET16;
            state_reg <= TSEG_IDLE;
        end else begin
            unique case (state_reg)
                TSEG_IDLE: begin
                    if (hit(bus.addr, `TSEG_OFF_EVGEN)) begin
                        evgen_reg <= bus.wdata & 16'h005f;
                        state_reg <= TSEG_EXEC;
                    end
                end
                TSEG_EXEC: begin
                    evgen_reg <= `TSEG_RESET16;
                    state_reg <= TSEG_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= `TSEG_RESET16;
            enable_reg <= `TSEG_RESET16;
            mode_reg <= `TSEG_RESET16;
            psc_reg <= `TSEG_RESET16;
            reload_reg <= `TSEG_RELOAD_RST;
            irqMask_reg <= 10'h000;
        end else begin
            if (hit(bus.addr, `TSEG_OFF_CTRL)) ctrl_reg <= bus.wdata;
            if (hit(bus.addr, `TSEG_OFF_ENABLE)) enable_reg <= bus.wdata;
            if (hit(bus.addr, `TSEG_OFF_MODE)) mode_reg <= bus.wdata;
            if (hit(bus.addr, `TSEG_OFF_PSC)) psc_reg <= bus.wdata;
            if (hit(bus.addr, `TSEG_OFF_RELOAD)) reload_reg <= bus.wdata;
            if (hit(bus.addr, `TSEG_OFF_IRQ_MASK)) irqMask_reg <= bus.wdata[9:0];
        end
    end

    // Counter and prescaler
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pscCnt_reg <= `TSEG_RESET16;
            cnt_reg <= `TSEG_RESET16;
        end else if (forceUpd) begin
            pscCnt_reg <= `TSEG_RESET16;
            cnt_reg <= ctrl_reg[`TSEG_BIT_DOWN] ? reload_reg : 16'h0000;
        end else if (hit(bus.addr, `TSEG_OFF_CNT)) begin
            cnt_reg <= bus.wdata;
        end else if (overflow) begin
            pscCnt_reg <= `TSEG_RESET16;
            cnt_reg <= ctrl_reg[`TSEG_BIT_DOWN] ? reload_reg : 16'h0000;
        end else if (pscCnt_reg == psc_reg) begin
            pscCnt_reg <= `TSEG_RESET16;
            cnt_reg <= ctrl_reg[`TSEG_BIT_DOWN] ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
        end else begin
            pscCnt_reg <= pscCnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) cc_reg[i] <= `TSEG_RESET16;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (capEvt[i]) cc_reg[i] <= cnt_reg;
                else if (!chInput[i] && hit(bus.addr, 6'(`TSEG_OFF_CC1 + i))) cc_reg[i] <= bus.wdata;
            end
        end
    end

    // Status flags: hardware set wins over software clear
    always_comb begin
        flags_next = flags_reg;
        if (wrStat) begin
            flags_next.upd = flags_reg.upd & bus.wdata[0];
            flags_next.cc = flags_reg.cc & bus.wdata[4:1];
            flags_next.trig = flags_reg.trig & bus.wdata[`TSEG_BIT_TRIG];
            flags_next.ovc = flags_reg.ovc & bus.wdata[12:9];
        end
        if (rdCc) flags_next.cc[rdCh] = 1'b0;
        if (updEvt) flags_next.upd = 1'b1;
        if (trigEvt) flags_next.trig = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (capEvt[i] && flags_reg.cc[i]) flags_next.ovc[i] = 1'b1;
            if (ccEvt[i]) flags_next.cc[i] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) flags_reg <= '0;
        else flags_reg <= flags_next;
    end

    // Requests to the DMA controller, one cycle per event when enabled
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) dma_reg <= 6'h00;
        else dma_reg <= {trigEvt, ccEvt, updEvt} & {enable_reg[14], enable_reg[12:8]};
    end
    assign dmaReq = dma_reg;

    // Sticky interrupt status, read clears, set wins
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqStat_reg <= 10'h000;
        end else begin
            irqStat_reg <= (bus.rd && bus.addr == `TSEG_OFF_IRQ_STAT ? 10'h000 : irqStat_reg)
                | {capEvt & flags_reg.cc, trigEvt, ccEvt & enable_reg[4:1], updEvt & enable_reg[0]};
        end
    end
    assign irq = |(irqStat_reg & irqMask_reg);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdData_reg <= `TSEG_RESET16;
        end else if (bus.rd) begin
            unique case (bus.addr)
                `TSEG_OFF_CTRL: rdData_reg <= ctrl_reg;
                `TSEG_OFF_ENABLE: rdData_reg <= enable_reg;
                `TSEG_OFF_STATUS: rdData_reg <= statusWord(flags_reg) & `TSEG_STATUS_MASK;
                `TSEG_OFF_MODE: rdData_reg <= mode_reg;
                `TSEG_OFF_IRQ_MASK: rdData_reg <= {6'h00, irqMask_reg};
                `TSEG_OFF_IRQ_STAT: rdData_reg <= {6'h00, irqStat_reg};
                `TSEG_OFF_CNT: rdData_reg <= cnt_reg;
                `TSEG_OFF_PSC: rdData_reg <= psc_reg;
                `TSEG_OFF_RELOAD: rdData_reg <= reload_reg;
                `TSEG_OFF_CC1, 6'h35, 6'h36, 6'h37: rdData_reg <= cc_reg[rdCh];
                // Unmapped and write-only addresses read zero
                default: rdData_reg <= `TSEG_RESET16;
            endcase
        end else begin
            rdData_reg <= `TSEG_RESET16;
        end
    end
    assign rdData = rdData_reg;
endmodule
`default_nettype wire

// ===== core/tseg_consts.svh
// Register offsets, field positions and reset values of the timer status/event block
`ifndef TSEG_CONSTS_SVH
`define TSEG_CONSTS_SVH
`define TSEG_ADDR_W 6
`define TSEG_OFF_CTRL 6'h00
`define TSEG_OFF_ENABLE 6'h0c
`define TSEG_OFF_STATUS 6'h10
`define TSEG_OFF_EVGEN 6'h14
`define TSEG_OFF_MODE 6'h18
`define TSEG_OFF_CNT 6'h24
`define TSEG_OFF_PSC 6'h28
`define TSEG_OFF_RELOAD 6'h2c
`define TSEG_OFF_CC1 6'h34
`define TSEG_OFF_IRQ_MASK 6'h1c
`define TSEG_OFF_IRQ_STAT 6'h20
`define TSEG_BIT_UPDATE 0
`define TSEG_BIT_TRIG 6
`define TSEG_BIT_OVC 9
`define TSEG_BIT_DOWN 4
`define TSEG_STATUS_MASK 16'h1e5f
`define TSEG_RESET16 16'h0000
`define TSEG_RELOAD_RST 16'hffff
`endif

// ===== core/tseg_pkg.sv
// Types of the timer status/event block
`default_nettype none
package tseg_pkg;
    typedef struct packed {
        logic [5:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tseg_bus_t;
    typedef struct packed {
        logic [3:0] ovc;
        logic trig;
        logic [3:0] cc;
        logic upd;
    } tseg_flags_t;
    typedef enum logic [1:0] {
        TSEG_IDLE,
        TSEG_EXEC
    } tseg_state_t;
endpackage
`default_nettype wire

// ===== tb/tseg_timer_status_event_properties.sv
// Port assertions of the timer status/event block
`timescale 1ns/1ps
`default_nettype none
`include "tseg_consts.svh"
module tseg_props
    import tseg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire tseg_bus_t bus,
    input wire logic [15:0] rdData,
    input wire logic [3:0] chCapture,
    input wire logic trigIn,
    input wire logic irq,
    input wire logic [5:0] dmaReq
);
    logic evW, rdS, evPrev;
    assign evW = bus.wr && bus.addr == `TSEG_OFF_EVGEN;
    assign rdS = bus.rd && bus.addr == `TSEG_OFF_STATUS;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) evPrev <= 1'b0;
        else evPrev <= evW;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    idle_zero_a: assert property (!$past(bus.rd) |-> rdData == 16'h0000)
        else $error("data without read");
    evgen_zero_a: assert property ($past(bus.rd && bus.addr == `TSEG_OFF_EVGEN)
        |-> rdData == 16'h0000) else $error("event bits read back");
    status_rsvd_a: assert property ($past(rdS) |-> (rdData & 16'he1a0) == 16'h0000)
        else $error("reserved status bit set");
    trig_in_a: assert property (trigIn ##1 !bus.wr ##1 rdS |=> rdData[6])
        else $error("trigger flag missing");
    evgen_trig_a: assert property (evW && !evPrev && bus.wdata[6] ##2 rdS |=> rdData[6])
        else $error("forced trigger flag missing");
    evgen_update_a: assert property (evW && !evPrev && bus.wdata[0] ##2 rdS |=> rdData[0])
        else $error("update flag missing");
    clear_zero_a: assert property (bus.wr && bus.addr == `TSEG_OFF_STATUS && !bus.wdata[6]
        && !trigIn && !$past(trigIn) && !evPrev ##1 !trigIn && !bus.wr ##1 rdS
        |=> !rdData[6]) else $error("trigger flag not cleared");
    irq_release_a: assert property ($fell(irq) |-> $past(bus.rd
        && bus.addr == `TSEG_OFF_IRQ_STAT || bus.wr && bus.addr == `TSEG_OFF_IRQ_MASK))
        else $error("interrupt dropped without cause");
    trig_dma_a: assert property (dmaReq[5] |-> $past(trigIn) || $past(evPrev))
        else $error("trigger request without event");
    cc_dma_a: assert property (|dmaReq[4:1] |-> $past(|chCapture) || $past(evPrev))
        else $error("channel request without event");
endmodule
bind tseg_timer_status_event tseg_props u_props (.ref_clk(ref_clk), .rst(rst), .bus(bus),
    .rdData(rdData), .chCapture(chCapture), .trigIn(trigIn), .irq(irq), .dmaReq(dmaReq));
`default_nettype wire

// ===== tb/tseg_timer_status_event_test.sv
// Directed bench of the timer status/event block
`timescale 1ns/1ps
`default_nettype none
`include "tseg_consts.svh"
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin badCount++; \
$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tseg_timer_status_event_test
    import tseg_pkg::*;
;
    localparam logic [5:0] ST = `TSEG_OFF_STATUS, EV = `TSEG_OFF_EVGEN, EN = `TSEG_OFF_ENABLE;
    localparam logic [5:0] MD = `TSEG_OFF_MODE, CT = `TSEG_OFF_CTRL, CN = `TSEG_OFF_CNT;
    localparam logic [5:0] PS = `TSEG_OFF_PSC, RL = `TSEG_OFF_RELOAD, C1 = `TSEG_OFF_CC1;
    localparam logic [5:0] IM = `TSEG_OFF_IRQ_MASK, IS = `TSEG_OFF_IRQ_STAT;
    logic ref_clk = 1'b0, rst = 1'b1, trigIn = 1'b0, irq;
    logic [3:0] chCapture = 4'h0;
    logic [15:0] rdData;
    logic [5:0] dmaReq, dmaSeen = 6'h00;
    tseg_bus_t bus = '0;
    int badCount = 0, numChecks = 0;
    always #25 ref_clk = ~ref_clk;
    logic dmaClr = 1'b0;
    // Collects request pulses between checks
    always @(posedge ref_clk) dmaSeen <= dmaClr ? dmaReq : dmaSeen | dmaReq;
    tseg_timer_status_event u_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rdData(rdData),
        .chCapture(chCapture), .trigIn(trigIn), .irq(irq), .dmaReq(dmaReq));
    task automatic wrapUp();
        $display("checks %0d errors %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic clrDma();
        dmaClr <= 1'b1;
        @(posedge ref_clk);
        dmaClr <= 1'b0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge ref_clk);
        bus.rd <= 1'b0;
        #1 `CHK(rdData, e)
    endtask
    task automatic scnTrig();
        rd(ST, 16'h0000);
        wr(EN, 16'h4040);
        @(posedge ref_clk);
        trigIn <= 1'b1;
        @(posedge ref_clk);
        trigIn <= 1'b0;
        rd(ST, 16'h0040);
        wr(ST, 16'hffff);
        rd(ST, 16'h0040);
        wr(ST, 16'h0000);
        rd(ST, 16'h0000);
        clrDma();
        wr(EV, 16'h0040);
        rd(ST, 16'h0040);
        `CHK(dmaSeen, 6'h20)
        rd(EV, 16'h0000);
        rd(IS, 16'h0020);
        wr(ST, 16'h0000);
    endtask
    task automatic scnUpdate();
        wr(PS, 16'h0003);
        wr(RL, 16'h1234);
        wr(CT, 16'h0010);
        wr(EN, 16'h0101);
        wr(IM, 16'h0001);
        clrDma();
        wr(EV, 16'h0001);
        rd(ST, 16'h0001);
        `CHK(dmaSeen, 6'h01)
        `CHK(irq, 1'b1)
        rd(CN, 16'h1234);
        rd(PS, 16'h0003);
        rd(IS, 16'h0001);
        `CHK(irq, 1'b0)
        wr(CT, 16'h0000);
        wr(IM, 16'h0000);
        wr(EV, 16'h0001);
        rd(CN, 16'h0000);
        `CHK(irq, 1'b0)
        wr(IM, 16'h0001);
        #1 `CHK(irq, 1'b1)
        rd(IS, 16'h0001);
        wr(ST, 16'h0000);
    endtask
    task automatic scnChan();
        wr(EN, 16'h0400);
        clrDma();
        wr(EV, 16'h0004);
        rd(ST, 16'h0004);
        `CHK(dmaSeen, 6'h04)
        for (int i = 1; i < 5; i++) begin
            wr(EV, 16'h0001 << i);
            wr(EV, 16'h0001 << i);
        end
        rd(ST, 16'h001e);
        wr(ST, 16'h0000);
    endtask
    task automatic scnCap();
        wr(MD, 16'h0001);
        wr(CT, 16'h0010);
        wr(EV, 16'h0001);
        wr(ST, 16'h0000);
        wr(EV, 16'h0002);
        rd(C1, 16'h1234);
        rd(ST, 16'h0000);
        wr(EV, 16'h0002);
        wr(EV, 16'h0002);
        rd(ST, 16'h0202);
        wr(ST, 16'h0000);
        repeat (2) begin
            @(posedge ref_clk);
            chCapture <= 4'h3;
            @(posedge ref_clk);
            chCapture <= 4'h0;
        end
        rd(ST, 16'h0202);
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        scnTrig();
        scnUpdate();
        scnChan();
        scnCap();
        wrapUp();
    end
endmodule
`default_nettype wire
